// *** rtl/tpg_top.sv ***
/*
  CSI-2 test pattern generator: indirect register block, frame sequencer
  and a two-entry output buffer towards the CSI-2 transmitter.
  Assumes the indirect access strobes and the transmitter share mclk_i.
*/
// Contract
// [R1] Generator runs only while the run bit is one; reset is stopped.
// [R2] Select bit zero sends color bars, one sends fixed color blocks.
// [R3] Bar code 00,01,10,11 gives 1,2,4,8 bars; eight after reset.
// [R4] Fixed color block length is the 4-bit size; software uses 1..15.
// [R5] Programmed virtual channel goes into every emitted packet.
// [R6] Programmed data type goes into each packet; reset 0x24. Code puts it in line packets only; frame start and end carry DT_FS and DT_FE.
// [R7] Active line is exactly the 16-bit line byte count long.
// [R8] All bars but the last are exactly the bar width in bytes.
// [R9] Last bar takes whatever bytes of the line remain.
// [R10] Each frame carries the 16-bit active line count of lines.
// [R11] Total line count is the frame length including blanking lines. Code makes the frame the larger of the total and active line counts.
// [R12] Line length resets to 0x07/0x80, 1920 bytes.
// [R13] Active line count resets to 0x01/0xE0, 480 lines.
// [R14] Total lines reset 0x02/0x0D; bar width resets 0x00/0xF0.
// [R15] Bars go out in ascending order starting at bar zero.
// [R16] Enabling starts at a frame start; disabling stops at frame end.
// [R17] Software selects block 0, writes offset, then accesses data.
// [R18] Each line is timed by a 16-bit period in rate-dependent units.
`timescale 1ns/1ps
module tpg_top (
  input wire logic mclk_i,                // Byte clock
  input wire logic resetn_i,              // Synchronous reset, low active
  input wire logic [1:0] ia_sel_i,        // Indirect register select
  input wire logic ia_wr_i,               // Indirect write strobe
  input wire logic ia_rd_i,               // Indirect read strobe
  input wire logic [7:0] ia_wdata_i,      // Indirect write data
  output logic [7:0] ia_rdata_o,          // Indirect read data
  input wire logic [1:0] csi_rate_i,      // CSI-2 lane rate code
  output logic [7:0] tx_data_o,           // Packet byte
  output logic tx_last_o,                 // Last byte of packet
  output logic tx_valid_o,                // Byte valid
  input wire logic tx_ready_i,            // Transmitter takes byte
  output logic gen_busy_o                 // Frame in progress
);
  import tpg_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] rst_val(input logic [3:0] i);
    case (i)
      OFS_CTL: rst_val = RST_CTL;
      OFS_CFG: rst_val = RST_CFG;
      OFS_DI: rst_val = RST_DI;
      OFS_LINE_HI: rst_val = RST_LINE_HI;
      OFS_LINE_LO: rst_val = RST_LINE_LO;
      OFS_BAR_HI: rst_val = RST_BAR_HI;
      OFS_BAR_LO: rst_val = RST_BAR_LO;
      OFS_ACT_HI: rst_val = RST_ACT_HI;
      OFS_ACT_LO: rst_val = RST_ACT_LO;
      OFS_TOT_HI: rst_val = RST_TOT_HI;
      OFS_TOT_LO: rst_val = RST_TOT_LO;
      OFS_LP_HI: rst_val = RST_LP_HI;
      OFS_LP_LO: rst_val = RST_LP_LO;
      default: rst_val = RST_CTL;
    endcase
  endfunction : rst_val

  function automatic logic [7:0] wr_mask(input logic [3:0] i);
    case (i)
      OFS_CTL: wr_mask = MASK_CTL;
      OFS_CFG: wr_mask = MASK_CFG;
      default: wr_mask = MASK_ALL;
    endcase
  endfunction : wr_mask

  function automatic logic [3:0] bar_total(input logic [1:0] code);
    case (code)
      2'b00: bar_total = 4'h1;
      2'b01: bar_total = 4'h2;
      2'b10: bar_total = 4'h4;
      default: bar_total = 4'h8;
    endcase
  endfunction : bar_total

  function automatic logic [31:0] unit_ps(input logic [1:0] rate);
    case (rate)
      RATE_400: unit_ps = UNIT_PS_400;
      RATE_1200: unit_ps = UNIT_PS_1200;
      default: unit_ps = UNIT_PS_FAST;
    endcase
  endfunction : unit_ps

  // ----------------------------------------
  // Indirect access registers
  // ----------------------------------------
  logic [7:0] ia_ctl_ff;
  logic [7:0] ia_addr_ff;
  logic [7:0] ia_rdata_ff;
  logic [7:0] cfg_ff [OFS_CTL:OFS_LP_LO];
  logic pgen_hit;
  logic data_acc;
  logic [3:0] idx;

  assign pgen_hit = (ia_ctl_ff[IA_BLK_MSB:IA_BLK_LSB] == IA_BLK_PGEN) &&
                    (ia_addr_ff >= OFS_FIRST) && (ia_addr_ff <= OFS_LAST); // R17
  assign data_acc = (ia_wr_i || ia_rd_i) && (ia_sel_i == SEL_DATA);
  assign idx = ia_addr_ff[IDX_W-1:0];

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ia_ctl_ff <= RST_CTL;
      ia_addr_ff <= RST_CTL;
    end else begin
      if (ia_wr_i && ia_sel_i == SEL_CTL) begin
        ia_ctl_ff <= ia_wdata_i;
      end
      if (ia_wr_i && ia_sel_i == SEL_ADDR) begin
        ia_addr_ff <= ia_wdata_i;
      end else if (data_acc && ia_ctl_ff[IA_AUTO_BIT]) begin
        ia_addr_ff <= ia_addr_ff + 8'h01; // R17
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      for (int i = int'(OFS_CTL); i <= int'(OFS_LP_LO); i++) begin
        cfg_ff[i] <= rst_val(4'(i)); // R12 R13 R14
      end
    end else if (ia_wr_i && ia_sel_i == SEL_DATA && pgen_hit) begin
      cfg_ff[idx] <= ia_wdata_i & wr_mask(idx);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ia_rdata_ff <= RST_CTL;
    end else if (ia_rd_i) begin
      case (ia_sel_i)
        SEL_CTL: ia_rdata_ff <= ia_ctl_ff;
        SEL_ADDR: ia_rdata_ff <= ia_addr_ff;
        SEL_DATA: ia_rdata_ff <= pgen_hit ? cfg_ff[idx] : RST_CTL;
        default: ia_rdata_ff <= RST_CTL;
      endcase
    end
  end

  // ----------------------------------------
  // Decoded configuration
  // ----------------------------------------
  logic run;
  logic solid;
  logic [3:0] nbars;
  logic [3:0] blk_size;
  logic [1:0] vc;
  logic [5:0] dt;
  logic [15:0] line_bytes;
  logic [15:0] bar_w;
  logic [15:0] act_lines;
  logic [15:0] tot_lines;
  logic [31:0] period_ps;

  assign run = cfg_ff[OFS_CTL][CTL_RUN_BIT];
  assign solid = cfg_ff[OFS_CFG][CFG_SOLID_BIT];
  assign nbars = bar_total(cfg_ff[OFS_CFG][CFG_BARS_MSB:CFG_BARS_LSB]); // R3
  assign blk_size = cfg_ff[OFS_CFG][CFG_BLK_MSB:CFG_BLK_LSB];
  assign vc = cfg_ff[OFS_DI][DI_VC_MSB:DI_VC_LSB];
  assign dt = cfg_ff[OFS_DI][DI_DT_MSB:DI_DT_LSB];
  assign line_bytes = {cfg_ff[OFS_LINE_HI], cfg_ff[OFS_LINE_LO]}; // R7
  assign bar_w = {cfg_ff[OFS_BAR_HI], cfg_ff[OFS_BAR_LO]};
  assign act_lines = {cfg_ff[OFS_ACT_HI], cfg_ff[OFS_ACT_LO]}; // R10
  assign tot_lines = {cfg_ff[OFS_TOT_HI], cfg_ff[OFS_TOT_LO]}; // R11
  assign period_ps = 32'({cfg_ff[OFS_LP_HI], cfg_ff[OFS_LP_LO]}) *
                     unit_ps(csi_rate_i); // R18

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  tpg_state_t state_ff;
  tpg_state_t nxt_state;
  logic [1:0] hdr_cnt_ff;
  logic [15:0] byte_cnt_ff;
  logic [15:0] bar_cnt_ff;
  logic [2:0] bar_idx_ff;
  logic [3:0] blk_cnt_ff;
  logic [2:0] blk_idx_ff;
  logic [15:0] line_cnt_ff;
  logic [15:0] frame_num_ff;
  logic [31:0] elapsed_ff;
  logic busy_ff;
  logic in_valid;
  logic in_ready;
  logic emit;
  logic hdr_done;
  logic line_end;
  logic last_bar;
  logic [7:0] in_data;
  logic in_last;

  assign in_valid = (state_ff == ST_FS) || (state_ff == ST_FE) ||
                    (state_ff == ST_LHDR) || (state_ff == ST_LDATA);
  assign emit = in_valid && in_ready;
  assign hdr_done = hdr_cnt_ff == HDR_LAST;
  assign line_end = byte_cnt_ff == 16'(line_bytes - 16'h0001); // R7
  assign last_bar = 4'(bar_idx_ff) == 4'(nbars - 4'h1);

  always_comb begin
    in_data = PALETTE[bar_idx_ff];
    in_last = 1'b0;
    case (state_ff)
      ST_FS, ST_FE, ST_LHDR: begin
        in_last = hdr_done && (state_ff != ST_LHDR || line_bytes == 16'h0000);
        case (hdr_cnt_ff)
          2'h0: in_data = {vc, (state_ff == ST_FS) ? DT_FS :
                           (state_ff == ST_FE) ? DT_FE : dt}; // R5 R6
          2'h1: in_data = (state_ff == ST_LHDR) ? line_bytes[7:0] : frame_num_ff[7:0];
          default: in_data = (state_ff == ST_LHDR) ? line_bytes[15:8] : frame_num_ff[15:8];
        endcase
      end
      ST_LDATA: begin
        in_data = solid ? PALETTE[blk_idx_ff] : PALETTE[bar_idx_ff]; // R2
        in_last = line_end;
      end
      default: begin
        in_data = PALETTE[bar_idx_ff];
        in_last = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (run) nxt_state = ST_FS; // R1 R16
      ST_FS: if (emit && hdr_done) nxt_state = ST_LINE;
      ST_LINE: begin
        if (line_cnt_ff >= tot_lines && line_cnt_ff >= act_lines) begin
          nxt_state = ST_FE; // R11
        end else if (line_cnt_ff < act_lines) begin
          nxt_state = ST_LHDR; // R10
        end else begin
          nxt_state = ST_LWAIT;
        end
      end
      ST_LHDR: begin
        if (emit && hdr_done) begin
          nxt_state = (line_bytes == 16'h0000) ? ST_LWAIT : ST_LDATA;
        end
      end
      ST_LDATA: if (emit && line_end) nxt_state = ST_LWAIT;
      ST_LWAIT: if (elapsed_ff >= period_ps) nxt_state = ST_LINE; // R18
      ST_FE: if (emit && hdr_done) nxt_state = run ? ST_FS : ST_IDLE; // R16
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE; // R1
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state != ST_IDLE;
    end
  end

  // Header byte index, line and frame counters
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      hdr_cnt_ff <= 2'h0;
      line_cnt_ff <= 16'h0000;
      frame_num_ff <= 16'h0000;
    end else begin
      if (emit && state_ff != ST_LDATA) begin
        hdr_cnt_ff <= hdr_done ? 2'h0 : hdr_cnt_ff + 2'h1;
      end
      if (state_ff == ST_FS) begin
        line_cnt_ff <= 16'h0000;
      end else if (state_ff == ST_LWAIT && nxt_state == ST_LINE) begin
        line_cnt_ff <= line_cnt_ff + 16'h0001;
      end
      if (state_ff == ST_FE && emit && hdr_done) begin
        frame_num_ff <= frame_num_ff + 16'h0001;
      end
    end
  end

  // Line period timer, restarted as each line begins
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || state_ff == ST_LINE) begin
      elapsed_ff <= 32'h0000_0000; // R18
    end else if (elapsed_ff < period_ps) begin
      elapsed_ff <= elapsed_ff + CLK_PERIOD_PS;
    end
  end

  // Bar and block position within the active line
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || state_ff == ST_LHDR) begin
      byte_cnt_ff <= 16'h0000;
      bar_cnt_ff <= 16'h0000;
      bar_idx_ff <= 3'h0; // R15
      blk_cnt_ff <= 4'h0;
      blk_idx_ff <= 3'h0;
    end else if (emit && state_ff == ST_LDATA) begin
      byte_cnt_ff <= byte_cnt_ff + 16'h0001;
      if (!last_bar && 16'(bar_cnt_ff + 16'h0001) >= bar_w) begin
        bar_cnt_ff <= 16'h0000; // R8
        bar_idx_ff <= bar_idx_ff + 3'h1; // R15
      end else begin
        bar_cnt_ff <= bar_cnt_ff + 16'h0001; // R9
      end
      if (4'(blk_cnt_ff + 4'h1) >= blk_size) begin
        blk_cnt_ff <= 4'h0; // R4
        blk_idx_ff <= blk_idx_ff + 3'h1;
      end else begin
        blk_cnt_ff <= blk_cnt_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  logic out_valid_ff;
  logic [8:0] out_ff;
  logic skid_valid_ff;
  logic [8:0] skid_ff;

  assign in_ready = !skid_valid_ff;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      out_valid_ff <= 1'b0;
      out_ff <= 9'h000;
      skid_valid_ff <= 1'b0;
      skid_ff <= 9'h000;
    end else if (tx_ready_i || !out_valid_ff) begin
      if (skid_valid_ff) begin
        out_ff <= skid_ff;
        out_valid_ff <= 1'b1;
        skid_valid_ff <= 1'b0;
      end else begin
        out_ff <= {in_last, in_data};
        out_valid_ff <= emit;
      end
    end else if (emit) begin
      skid_ff <= {in_last, in_data};
      skid_valid_ff <= 1'b1;
    end
  end

  assign tx_data_o = out_ff[7:0];
  assign tx_last_o = out_ff[8];
  assign tx_valid_o = out_valid_ff;
  assign ia_rdata_o = ia_rdata_ff;
  assign gen_busy_o = busy_ff;
endmodule : tpg_top

// *** rtl/tpg_pkg.sv ***
/*
  Constants shared by the CSI-2 test pattern generator: indirect register
  offsets, reset values, field positions, packet codes, line timing units.
  Assumes a single 10 MHz clock and the byte-wide indirect access port.
*/
package tpg_pkg;
  // ----------------------------------------
  // Indirect register offsets (block 0)
  // ----------------------------------------
  localparam int IDX_W = 4;
  localparam logic [7:0] OFS_FIRST = 8'h01;
  localparam logic [7:0] OFS_LAST = 8'h0D;
  localparam logic [3:0] OFS_CTL = 4'h1;
  localparam logic [3:0] OFS_CFG = 4'h2;
  localparam logic [3:0] OFS_DI = 4'h3;
  localparam logic [3:0] OFS_LINE_HI = 4'h4;
  localparam logic [3:0] OFS_LINE_LO = 4'h5;
  localparam logic [3:0] OFS_BAR_HI = 4'h6;
  localparam logic [3:0] OFS_BAR_LO = 4'h7;
  localparam logic [3:0] OFS_ACT_HI = 4'h8;
  localparam logic [3:0] OFS_ACT_LO = 4'h9;
  localparam logic [3:0] OFS_TOT_HI = 4'hA;
  localparam logic [3:0] OFS_TOT_LO = 4'hB;
  localparam logic [3:0] OFS_LP_HI = 4'hC;
  localparam logic [3:0] OFS_LP_LO = 4'hD;
  // ----------------------------------------
  // Reset values and writable bits
  // ----------------------------------------
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h33;
  localparam logic [7:0] RST_DI = 8'h24;
  localparam logic [7:0] RST_LINE_HI = 8'h07;
  localparam logic [7:0] RST_LINE_LO = 8'h80;
  localparam logic [7:0] RST_BAR_HI = 8'h00;
  localparam logic [7:0] RST_BAR_LO = 8'hF0;
  localparam logic [7:0] RST_ACT_HI = 8'h01;
  localparam logic [7:0] RST_ACT_LO = 8'hE0;
  localparam logic [7:0] RST_TOT_HI = 8'h02;
  localparam logic [7:0] RST_TOT_LO = 8'h0D;
  localparam logic [7:0] RST_LP_HI = 8'h0C;
  localparam logic [7:0] RST_LP_LO = 8'h67;
  localparam logic [7:0] MASK_CTL = 8'h01;
  localparam logic [7:0] MASK_CFG = 8'hBF;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_RUN_BIT = 0;
  localparam int CFG_SOLID_BIT = 7;
  localparam int CFG_BARS_MSB = 5;
  localparam int CFG_BARS_LSB = 4;
  localparam int CFG_BLK_MSB = 3;
  localparam int CFG_BLK_LSB = 0;
  localparam int DI_VC_MSB = 7;
  localparam int DI_VC_LSB = 6;
  localparam int DI_DT_MSB = 5;
  localparam int DI_DT_LSB = 0;
  localparam int IA_AUTO_BIT = 1;
  localparam int IA_BLK_MSB = 5;
  localparam int IA_BLK_LSB = 2;
  localparam logic [3:0] IA_BLK_PGEN = 4'h0;
  localparam logic [1:0] SEL_CTL = 2'h0;
  localparam logic [1:0] SEL_ADDR = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  // ----------------------------------------
  // Packets, rates and timing
  // ----------------------------------------
  localparam logic [5:0] DT_FS = 6'h00;
  localparam logic [5:0] DT_FE = 6'h01;
  localparam logic [1:0] HDR_LAST = 2'h2;
  localparam logic [1:0] RATE_400 = 2'h0;
  localparam logic [1:0] RATE_800 = 2'h1;
  localparam logic [1:0] RATE_1200 = 2'h2;
  localparam logic [1:0] RATE_1600 = 2'h3;
  localparam longint CLK_FREQ_HZ = 64'd10000000;
  localparam logic [31:0] CLK_PERIOD_PS = 32'(64'd1000000000000 / CLK_FREQ_HZ);
  localparam logic [31:0] UNIT_PS_FAST = 32'd10000;
  localparam logic [31:0] UNIT_PS_1200 = 32'd13330;
  localparam logic [31:0] UNIT_PS_400 = 32'd20000;
  // Arbitrary byte per bar or block; the real color registers are elsewhere
  localparam logic [7:0] PALETTE [0:7] = '{8'hAA, 8'h33, 8'hF0, 8'h0F,
                                          8'h55, 8'hCC, 8'h3C, 8'hC3};
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_FS = 7'b0000010,
    ST_LINE = 7'b0000100,
    ST_LHDR = 7'b0001000,
    ST_LDATA = 7'b0010000,
    ST_LWAIT = 7'b0100000,
    ST_FE = 7'b1000000
  } tpg_state_t;
endpackage : tpg_pkg

// *** bench/tpg_sink.sv ***
/*
  Transmitter-side sink for the generator byte stream.
  Assumes one clock; stalls at random while stall_en_i is high.
*/
`timescale 1ns/1ps
module tpg_sink (
  input wire logic mclk_i,      // Clock
  input wire logic resetn_i,    // Reset, low active
  input wire logic [7:0] data_i, // Packet byte
  input wire logic last_i,      // Packet end
  input wire logic valid_i,     // Byte valid
  input wire logic stall_en_i,  // Allow random stalls
  output logic ready_o          // Byte taken
);
  logic [8:0] got[$];
  always @(posedge mclk_i) begin
    if (resetn_i && valid_i && ready_o) begin
      got.push_back({last_i, data_i});
    end
    ready_o <= resetn_i && (!stall_en_i || $urandom_range(0, 2) != 0);
  end
endmodule : tpg_sink

// *** bench/tpg_top_assertions.sv ***
/*
  Port checker for tpg_top: stream framing, stall hold, read data hold.
  Assumes the bind at the foot of this file.
*/
`timescale 1ns/1ps
module tpg_checker
  import tpg_pkg::*;
(
  input wire logic mclk_i,          // Clock
  input wire logic resetn_i,        // Reset
  input wire logic [1:0] ia_sel_i,  // Select
  input wire logic ia_wr_i,         // Write
  input wire logic ia_rd_i,         // Read
  input wire logic [7:0] ia_wdata_i, // Write data
  input wire logic [7:0] ia_rdata_o, // Read data
  input wire logic [1:0] csi_rate_i, // Rate
  input wire logic [7:0] tx_data_o, // Byte
  input wire logic tx_last_o,       // Last
  input wire logic tx_valid_o,      // Valid
  input wire logic tx_ready_i,      // Ready
  input wire logic gen_busy_o       // Busy
);
  logic tk;
  logic lng;
  logic [16:0] pos_ff;
  logic [5:0] dt_ff;
  logic [1:0] vc_ff;
  logic [15:0] wc_ff;
  logic [7:0] fn_ff;
  assign tk = tx_valid_o && tx_ready_i;
  assign lng = dt_ff != DT_FS && dt_ff != DT_FE;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) pos_ff <= 17'h0;
    else if (tk) pos_ff <= tx_last_o ? 17'h0 : pos_ff + 17'h1;
  end
  always_ff @(posedge mclk_i) begin
    if (tk && pos_ff == 17'h0) dt_ff <= tx_data_o[5:0];
    if (tk && pos_ff == 17'h0 && tx_data_o[5:0] == DT_FS) vc_ff <= tx_data_o[7:6];
    if (tk && pos_ff == 17'h1) wc_ff[7:0] <= tx_data_o;
    if (tk && pos_ff == 17'h2) wc_ff[15:8] <= tx_data_o;
    if (tk && pos_ff == 17'h1 && dt_ff == DT_FS) fn_ff <= tx_data_o;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled byte changed");
  property p_vc;
    tx_valid_o && pos_ff == 17'h0 && tx_data_o[5:0] != DT_FS |-> tx_data_o[7:6] == vc_ff;
  endproperty
  a_vc: assert property (p_vc)
    else $error("packet channel differs from frame start");
  property p_long;
    tk && tx_last_o && pos_ff != 17'h0 && lng |->
      (pos_ff == 17'h2 && {tx_data_o, wc_ff[7:0]} == 16'h0) ||
      (pos_ff > 17'h2 && pos_ff == {1'b0, wc_ff} + 17'h2);
  endproperty
  a_long: assert property (p_long)
    else $error("line payload length differs from count");
  property p_short;
    tk && pos_ff != 17'h0 && !lng |-> tx_last_o == (pos_ff == 17'h2);
  endproperty
  a_short: assert property (p_short)
    else $error("short packet length wrong");
  property p_pay0;
    tx_valid_o && pos_ff == 17'h3 && lng |-> tx_data_o == PALETTE[0];
  endproperty
  a_pay0: assert property (p_pay0)
    else $error("line does not start with bar zero");
  property p_rd;
    !ia_rd_i |=> $stable(ia_rdata_o);
  endproperty
  a_rd: assert property (p_rd)
    else $error("read data moved without read");
  property p_start;
    $rose(gen_busy_o) && !tx_valid_o |-> ##[1:3] (tx_valid_o && tx_data_o[5:0] == DT_FS);
  endproperty
  a_start: assert property (p_start)
    else $error("start without frame start packet");
  property p_fe;
    tx_valid_o && pos_ff == 17'h1 && dt_ff == DT_FE |-> tx_data_o == fn_ff;
  endproperty
  a_fe: assert property (p_fe)
    else $error("frame end number differs");
  c_stall: cover property (tx_valid_o && !tx_ready_i);
  c_wc0: cover property (tk && tx_last_o && lng && pos_ff == 17'h2);
  c_fe: cover property (tk && tx_last_o && dt_ff == DT_FE);
endmodule : tpg_checker
bind tpg_top tpg_checker chk_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .ia_sel_i(ia_sel_i),
  .ia_wr_i(ia_wr_i), .ia_rd_i(ia_rd_i), .ia_wdata_i(ia_wdata_i), .ia_rdata_o(ia_rdata_o),
  .csi_rate_i(csi_rate_i), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .gen_busy_o(gen_busy_o));

// *** bench/testbench.sv ***
/*
  Self-checking bench for tpg_top: register reset values, bar and fixed
  frames under random stalls. Assumes tpg_sink and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
  import tpg_pkg::*;
  logic mclk_i, resetn_i, ia_wr_i, ia_rd_i, tx_valid_o, tx_last_o, tx_ready_i;
  logic gen_busy_o, stall_en;
  logic [1:0] ia_sel_i, csi_rate_i;
  logic [7:0] ia_wdata_i, ia_rdata_o, tx_data_o;
  int fail_count, check_count, lb, bw, bc, nb, act, tot, solid, blk, vc, dt, fnum, k;
  logic [8:0] expq[$];
  localparam logic [7:0] RV [0:14] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00,
                                      8'hF0, 8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67,
                                      8'h00};
  tpg_top dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .ia_sel_i(ia_sel_i),
    .ia_wr_i(ia_wr_i), .ia_rd_i(ia_rd_i), .ia_wdata_i(ia_wdata_i), .ia_rdata_o(ia_rdata_o),
    .csi_rate_i(csi_rate_i), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .gen_busy_o(gen_busy_o));
  tpg_sink sink_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .data_i(tx_data_o),
    .last_i(tx_last_o), .valid_i(tx_valid_o), .stall_en_i(stall_en), .ready_o(tx_ready_i));
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic acc(input logic [1:0] s, input logic w, input logic [7:0] d);
    @(posedge mclk_i);
    ia_sel_i <= s;
    ia_wr_i <= w;
    ia_rd_i <= !w;
    ia_wdata_i <= d;
    @(posedge mclk_i);
    ia_wr_i <= 1'b0;
    ia_rd_i <= 1'b0;
  endtask : acc
  task automatic hdr(input logic [5:0] t, input logic [15:0] v, input logic l);
    expq.push_back({1'b0, vc[1:0], t});
    expq.push_back({1'b0, v[7:0]});
    expq.push_back({l, v[15:8]});
  endtask : hdr
  task automatic frame;
    int i, l, j;
    logic [7:0] v [0:11];
    v = '{{solid[0], 1'b0, bc[1:0], blk[3:0]}, {vc[1:0], dt[5:0]}, lb[15:8], lb[7:0],
          bw[15:8], bw[7:0], act[15:8], act[7:0], tot[15:8], tot[7:0], 8'h00, 8'h08};
    nb = 1 << bc;
    acc(SEL_CTL, 1'b1, 8'h02);
    acc(SEL_ADDR, 1'b1, 8'h02);
    for (i = 0; i < 12; i++) acc(SEL_DATA, 1'b1, v[i]);
    expq.delete();
    sink_u.got.delete();
    hdr(DT_FS, fnum[15:0], 1'b1);
    for (l = 0; l < (tot > act ? tot : act); l++) begin
      if (l < act) begin
        hdr(dt[5:0], lb[15:0], lb == 0);
        for (i = 0; i < lb; i++) begin
          j = solid ? (i / blk) % 8 : i / bw;
          if (!solid && j > nb - 1) j = nb - 1;
          expq.push_back({i == lb - 1, PALETTE[j]});
        end
      end
    end
    hdr(DT_FE, fnum[15:0], 1'b1);
    csi_rate_i <= 2'($urandom_range(0, 3));
    acc(SEL_ADDR, 1'b1, 8'h01);
    acc(SEL_DATA, 1'b1, 8'h01);
    acc(SEL_ADDR, 1'b1, 8'h01);
    acc(SEL_DATA, 1'b1, 8'h00);
    j = 0;
    while ((gen_busy_o !== 1'b0 || tx_valid_o !== 1'b0) && j < 20000) begin
      @(posedge mclk_i);
      j++;
    end
    if (j >= 20000) begin
      $display("wrong value at %0t: frame did not finish", $time);
      fail_count++;
    end
    repeat (20) @(posedge mclk_i);
    chk(9'(sink_u.got.size()), 9'(expq.size()));
    for (i = 0; i < expq.size() && i < sink_u.got.size(); i++) begin
      chk(sink_u.got[i], expq[i]);
    end
    fnum++;
  endtask : frame
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(90));
    {resetn_i, ia_wr_i, ia_rd_i, ia_sel_i, ia_wdata_i, csi_rate_i} = '0;
    stall_en = 1'b1;
    {fail_count, check_count, fnum} = '0;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    acc(SEL_CTL, 1'b1, 8'h00);
    for (k = 0; k < 15; k++) begin
      acc(SEL_ADDR, 1'b1, k == 14 ? 8'h0E : 8'(k));
      acc(SEL_DATA, 1'b0, 8'h00);
      #1 chk({1'b0, ia_rdata_o}, {1'b0, RV[k]});
    end
    acc(SEL_ADDR, 1'b1, 8'h01);
    acc(SEL_DATA, 1'b1, 8'hFE);
    acc(SEL_DATA, 1'b0, 8'h00);
    #1 chk({gen_busy_o, ia_rdata_o}, 9'h000);
    {lb, bw, act, tot} = {32'd13, 32'd2, 32'd2, 32'd3};
    {vc, dt, solid, blk} = {32'd1, 32'd36, 32'd0, 32'd3};
    for (bc = 0; bc < 4; bc++) frame();
    solid = 1;
    repeat (2) begin
      blk = $urandom_range(1, 15);
      lb = $urandom_range(9, 40);
      vc = $urandom_range(0, 3);
      dt = $urandom_range(2, 63);
      {act, tot} = {32'd3, 32'd1};
      frame();
    end
    {lb, act, tot} = {32'd0, 32'd1, 32'd4};
    frame();
    report_and_stop();
  end
  initial begin
    #3000000;
    fail_count++;
    report_and_stop();
  end
endmodule : testbench
